/* addr_match_map.vh */
/*
 Address recognition constants: pad levels, call address defaults, enables.
 Assumes inclusion by the address match front end and its pad decoder.
*/
`ifndef ADDR_MATCH_MAP_VH
`define ADDR_MATCH_MAP_VH

// Pad level codes, 0 = tied low .. 4 = tied high
`define LEVEL_TIED_LOW 3'h0
`define LEVEL_PULLED_LOW 3'h1
`define LEVEL_FLOATING 3'h2
`define LEVEL_PULLED_HIGH 3'h3
`define LEVEL_TIED_HIGH 3'h4

// Weights of the quinary digits and the offset of the lowest address
`define PAD_TWO_WEIGHT 7'h19
`define PAD_ONE_WEIGHT 7'h05
`define ADDR_OFFSET 7'h01

// Group call address reset value (byte form, direction bit ignored)
`define GROUP_CALL_RESET 8'he0
`define GROUP_CALL_EN_RESET 1'b1

// Sub call enables after reset: a on, b and c off
`define SUB_CALL_EN_RESET 3'h1

// Reset call second byte following the general call byte
`define GENERAL_CALL_BYTE 8'h00
`define BUS_RESET_CALL_BYTE 8'h06

// Cycles of settled pad decode before the address is latched
`define PAD_SETTLE_CYCLES 4'h8

`endif

/* i2c_master_model.sv */
/*
 Behavioural bus master: START, STOP, byte out with acknowledge sample.
 Assumes the bench resolves the pulled-up SDA wire.
*/
`timescale 1ns/100ps
module i2c_master_model (
	// Bus
	output logic scl_o,
	output logic sda_o,
	input logic sda_i
);
	// Both lines released and standing high between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Starts 10 ns late, so each START shifts the phase by 10 ns and later pin changes can land on a clock edge
	task start;
		#10 sda_o = 1'b1;
		#80 scl_o = 1'b1;
		#80 sda_o = 1'b0;
		#80 scl_o = 1'b0;
		#80;
	endtask
	task stop;
		#80 sda_o = 1'b0;
		#80 scl_o = 1'b1;
		#80 sda_o = 1'b1;
		#80;
	endtask
	// MSB first; bit 0 of an address byte is the direction
	task xfer(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_o = b[i];
			#80 scl_o = 1'b1;
			#160 scl_o = 1'b0;
			#80;
		end
		sda_o = 1'b1;
		#80 scl_o = 1'b1;
		#120 ack = !sda_i;
		#40 scl_o = 1'b0;
		// The target lets go of SDA some clocks after this fall
		#240;
	endtask
endmodule // i2c_master_model

/* i2c_target_address_match.v */
/*
 I2C target address recognition: pad address latch, group and sub call
 matching, acknowledge of the address byte, pointer byte capture and the
 bus reset call. Assumes SCL/SDA pins and pad levels are asynchronous to clk_i
 and are resynchronised here; clk_i is much faster than SCL.
*/
`timescale 1ns/100ps
`include "addr_match_map.vh"

module i2c_target_address_match #(
	parameter [7:0] SUB_CALL_RESET = 8'hd4 // Arbitrary class code
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Serial bus
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_n_o,
	// Address pads
	input wire [2:0] addr_pad_zero_i,
	input wire [2:0] addr_pad_one_i,
	input wire [2:0] addr_pad_two_i,
	output reg pad_sense_en_o,
	// Call address programming from the register stage
	input wire [7:0] group_call_address_i,
	input wire group_call_wr_i,
	input wire group_call_en_i,
	input wire [7:0] sub_call_address_i,
	input wire [2:0] sub_call_wr_i,
	input wire [2:0] sub_call_en_i,
	input wire sub_call_en_wr_i,
	// Results to the register stage
	output reg [6:0] own_address_o,
	output reg address_valid_o,
	output reg matched_o,
	output reg read_o,
	output reg [6:0] pointer_o,
	output reg pointer_increment_flag_o,
	output reg pointer_valid_o,
	output reg bus_reset_call_o,
	output reg [7:0] group_call_address_o,
	output reg group_call_en_o,
	output reg [7:0] sub_call_address_a_o,
	output reg [7:0] sub_call_address_b_o,
	output reg [7:0] sub_call_address_c_o,
	output reg [2:0] sub_call_en_o
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_ACK = 3'h2;
	localparam ST_PTR = 3'h3;
	localparam ST_DATA = 3'h4;
	localparam ST_RST = 3'h5;
	localparam ST_SKIP = 3'h6;

	reg [1:0] scl_sync;
	reg [1:0] sda_sync;
	reg scl_prev;
	reg sda_prev;
	reg [8:0] pad_sync_a;
	reg [8:0] pad_sync_b;
	reg [3:0] settle;
	reg [2:0] state;
	reg [2:0] after_ack;
	reg [3:0] bit_cnt;
	reg [7:0] shift;
	reg ack_drive;
	reg is_general;
	reg reset_pending;
	reg soft_reset;
	wire scl_rise;
	wire scl_fall;
	wire start_cond;
	wire stop_cond;
	wire [6:0] decoded_address;
	wire decoded_valid;
	wire addr_hit;
	wire [7:0] sub_call_rd [0:2];
	wire [2:0] sub_hit;

	pad_level_decode u_decode (
		.addr_pad_zero_i(pad_sync_b[2:0]),
		.addr_pad_one_i(pad_sync_b[5:3]),
		.addr_pad_two_i(pad_sync_b[8:6]),
		.address_o(decoded_address),
		.valid_o(decoded_valid)
	);

	// Compare the top seven bits of a byte against a call address
	function call_match;
		input [7:0] rx;
		input [7:0] call;
		input en;
		begin
			call_match = en && (rx[7:1] == call[7:1]);
		end
	endfunction

	assign sub_call_rd[0] = sub_call_address_a_o;
	assign sub_call_rd[1] = sub_call_address_b_o;
	assign sub_call_rd[2] = sub_call_address_c_o;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sub
			assign sub_hit[gi] = call_match(shift, sub_call_rd[gi], sub_call_en_o[gi]);
		end
	endgenerate

	assign scl_rise = scl_sync[1] && !scl_prev;
	assign scl_fall = !scl_sync[1] && scl_prev;
	assign start_cond = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
	assign stop_cond = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
	// Own address only counts once latched
	assign addr_hit = (address_valid_o && shift[7:1] == own_address_o) ||
		call_match(shift, group_call_address_o, group_call_en_o) || (|sub_hit);

	// Bus pins and pads: two flops before any use
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			pad_sync_a <= 9'h000;
			pad_sync_b <= 9'h000;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
			pad_sync_a <= {addr_pad_two_i, addr_pad_one_i, addr_pad_zero_i};
			pad_sync_b <= pad_sync_a;
		end
	end

	// Pad address latch; a bus reset call restarts it like a reset
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_sense_en_o <= 1'b1;
			settle <= 4'h0;
			address_valid_o <= 1'b0;
			own_address_o <= 7'h00;
		end else if (soft_reset) begin
			pad_sense_en_o <= 1'b1;
			settle <= 4'h0;
			address_valid_o <= 1'b0;
		end else if (pad_sense_en_o) begin
			// Wait for the synchroniser and pad sense to settle
			if (settle < `PAD_SETTLE_CYCLES)
				settle <= settle + 4'h1;
			else if (decoded_valid) begin
				own_address_o <= decoded_address;
				address_valid_o <= 1'b1;
				pad_sense_en_o <= 1'b0;
			end
		end
	end

	// Call address registers, volatile; reset call restores defaults
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			group_call_address_o <= `GROUP_CALL_RESET;
			group_call_en_o <= `GROUP_CALL_EN_RESET;
			sub_call_address_a_o <= SUB_CALL_RESET;
			sub_call_address_b_o <= SUB_CALL_RESET;
			sub_call_address_c_o <= SUB_CALL_RESET;
			sub_call_en_o <= `SUB_CALL_EN_RESET;
		end else if (soft_reset) begin
			group_call_address_o <= `GROUP_CALL_RESET;
			group_call_en_o <= `GROUP_CALL_EN_RESET;
			sub_call_address_a_o <= SUB_CALL_RESET;
			sub_call_address_b_o <= SUB_CALL_RESET;
			sub_call_address_c_o <= SUB_CALL_RESET;
			sub_call_en_o <= `SUB_CALL_EN_RESET;
		end else begin
			if (group_call_wr_i) begin
				group_call_address_o <= group_call_address_i;
				group_call_en_o <= group_call_en_i;
			end
			if (sub_call_wr_i[0])
				sub_call_address_a_o <= sub_call_address_i;
			if (sub_call_wr_i[1])
				sub_call_address_b_o <= sub_call_address_i;
			if (sub_call_wr_i[2])
				sub_call_address_c_o <= sub_call_address_i;
			if (sub_call_en_wr_i)
				sub_call_en_o <= sub_call_en_i;
		end
	end

	// Bit level engine: sample on SCL rise, change SDA after SCL fall
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
			after_ack <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			ack_drive <= 1'b0;
			is_general <= 1'b0;
			reset_pending <= 1'b0;
			soft_reset <= 1'b0;
			matched_o <= 1'b0;
			read_o <= 1'b0;
			pointer_o <= 7'h00;
			pointer_increment_flag_o <= 1'b0;
			pointer_valid_o <= 1'b0;
			bus_reset_call_o <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else begin
			soft_reset <= 1'b0;
			bus_reset_call_o <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_n_o <= !ack_drive;
			if (start_cond) begin
				// Every START is followed by an address byte
				state <= ST_ADDR;
				bit_cnt <= 4'h0;
				ack_drive <= 1'b0;
				matched_o <= 1'b0;
				pointer_valid_o <= 1'b0;
				reset_pending <= 1'b0;
			end else if (stop_cond) begin
				state <= ST_IDLE;
				ack_drive <= 1'b0;
				matched_o <= 1'b0;
				// Reset takes effect at STOP, after the call was acknowledged
				if (reset_pending) begin
					soft_reset <= 1'b1;
					bus_reset_call_o <= 1'b1;
				end
				reset_pending <= 1'b0;
			end else begin
				case (state)
				ST_ADDR, ST_PTR, ST_RST, ST_DATA: begin
					if (scl_rise && bit_cnt < 4'h8) begin
						shift <= {shift[6:0], sda_sync[1]};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						state <= ST_ACK;
						after_ack <= ST_SKIP;
						if (state == ST_ADDR) begin
							is_general <= (shift == `GENERAL_CALL_BYTE);
							if (shift == `GENERAL_CALL_BYTE) begin
								ack_drive <= 1'b1;
								after_ack <= ST_RST;
							end else if (addr_hit) begin
								ack_drive <= 1'b1;
								matched_o <= 1'b1;
								read_o <= shift[0];
								after_ack <= shift[0] ? ST_DATA : ST_PTR;
							end
						end else if (state == ST_PTR) begin
							pointer_o <= shift[6:0];
							pointer_increment_flag_o <= shift[7];
							pointer_valid_o <= 1'b1;
							ack_drive <= 1'b1;
							after_ack <= ST_DATA;
						end else if (state == ST_RST) begin
							if (is_general && shift == `BUS_RESET_CALL_BYTE) begin
								ack_drive <= 1'b1;
								reset_pending <= 1'b1;
							end
						end else begin
							// Data bytes belong to the register stage
							after_ack <= ST_DATA;
						end
					end
				end
				ST_ACK: begin
					// Hold SDA low through the ninth clock
					if (scl_fall) begin
						ack_drive <= 1'b0;
						state <= after_ack;
					end
				end
				ST_SKIP, ST_IDLE: begin
					ack_drive <= 1'b0;
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule // i2c_target_address_match

/* i2c_target_address_match_asserts.sv */
/*
 Port checker for the address match front end.
 Assumes one clock domain and an active low asynchronous reset.
*/
`timescale 1ns/100ps
module i2c_target_address_match_asserts #(
	parameter [7:0] SUB_CALL_RESET = 8'hd4
) (
	input logic clk_i, rst_n_i, sda_o, sda_oe_n_o, pad_sense_en_o,
	input logic [2:0] addr_pad_zero_i, addr_pad_one_i, addr_pad_two_i,
	input logic [7:0] group_call_address_i, group_call_address_o, sub_call_address_a_o,
	input logic group_call_wr_i, group_call_en_i, group_call_en_o, address_valid_o,
	input logic matched_o, read_o, pointer_valid_o, bus_reset_call_o,
	input logic [6:0] own_address_o,
	input logic [2:0] sub_call_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ack_drive_low: assert property (!sda_oe_n_o |-> !sda_o)
		else $error("SDA driven high");
	a_ack_length: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*3] ##[1:12] sda_oe_n_o)
		else $error("ACK length wrong");
	a_pads_off: assert property (address_valid_o |-> !pad_sense_en_o)
		else $error("pads sensed after latch");
	a_addr_value: assert property ($rose(address_valid_o) |->
		own_address_o == 7'(25 * addr_pad_two_i + 5 * addr_pad_one_i + addr_pad_zero_i + 1))
		else $error("own address wrong");
	a_reset_calls: assert property ($rose(rst_n_i) |->
		group_call_address_o == 8'he0 && group_call_en_o
		&& sub_call_en_o == 3'h1 && sub_call_address_a_o == SUB_CALL_RESET)
		else $error("call defaults wrong");
	a_bus_reset: assert property (bus_reset_call_o |=> !bus_reset_call_o ##[0:3]
		(group_call_address_o == 8'he0 && sub_call_en_o == 3'h1))
		else $error("bus reset call ignored");
	a_ptr_write: assert property ($rose(pointer_valid_o) |-> matched_o && !read_o)
		else $error("pointer without write");
	a_group_write: assert property (group_call_wr_i |=>
		group_call_address_o == $past(group_call_address_i) && group_call_en_o == $past(group_call_en_i))
		else $error("group write lost");
endmodule // i2c_target_address_match_asserts

bind i2c_target_address_match i2c_target_address_match_asserts #(.SUB_CALL_RESET(SUB_CALL_RESET)) chk (.*);

/* i2c_target_address_match_tb_top.sv */
/*
 Bench for the address match front end.
 Assumes the master model on a pulled-up SDA wire.
*/
`timescale 1ns/100ps
module i2c_target_address_match_tb_top;
	logic clk_i, rst_n_i, scl_i, sda_o, sda_oe_n_o, m_sda, ack, group_call_wr_i, group_call_en_i;
	logic sub_call_en_wr_i, address_valid_o, matched_o, read_o, pointer_increment_flag_o, pointer_valid_o;
	logic bus_reset_call_o, group_call_en_o, pad_sense_en_o;
	logic [2:0] addr_pad_zero_i, addr_pad_one_i, addr_pad_two_i, sub_call_wr_i, sub_call_en_i, sub_call_en_o;
	logic [7:0] group_call_address_i, sub_call_address_i, group_call_address_o;
	logic [7:0] sub_call_address_a_o, sub_call_address_b_o, sub_call_address_c_o;
	logic [6:0] own_address_o, pointer_o;
	int fails, check_count, cyc;
	wire sda_i = m_sda & (sda_oe_n_o | sda_o);
	i2c_target_address_match DUT (.*);
	i2c_master_model m (.scl_o(scl_i), .sda_o(m_sda), .sda_i(sda_i));
	initial begin
		{clk_i, rst_n_i, group_call_wr_i, group_call_en_i, sub_call_en_wr_i} = '0;
		{sub_call_wr_i, sub_call_en_i, group_call_address_i, sub_call_address_i} = '0;
		// Pads give 6fh, clear of the group default and reserved ranges
		addr_pad_two_i = 3'h4;
		addr_pad_one_i = 3'h2;
		addr_pad_zero_i = 3'h0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			end_sim;
		end
	end
	task chk(input string n, input logic [7:0] e, s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task frame(input logic [7:0] a, input logic e);
		m.start;
		m.xfer(a, ack);
		chk("ack", {7'h0, e}, {7'h0, ack});
		m.stop;
	endtask
	task t_defaults;
		chk("grp", 8'he0, group_call_address_o);
		chk("grp_en", 8'h1, {7'h0, group_call_en_o});
		chk("sub_a", 8'hd4, sub_call_address_a_o);
		chk("sub_en", 8'h1, {5'h0, sub_call_en_o});
		chk("sense", 8'h0, {7'h0, pad_sense_en_o});
		chk("valid", 8'h1, {7'h0, address_valid_o});
		chk("sub_b", 8'hd4, sub_call_address_b_o);
		chk("sub_c", 8'hd4, sub_call_address_c_o);
	endtask
	task t_own;
		chk("own", 8'h6f, {1'b0, own_address_o});
		m.start;
		m.xfer(8'hde, ack);
		chk("ack", 8'h1, {7'h0, ack});
		chk("rd", 8'h0, {7'h0, read_o});
		chk("match", 8'h1, {7'h0, matched_o});
		m.xfer(8'h85, ack);
		chk("ptr", 8'h85, {pointer_increment_flag_o, pointer_o});
		chk("ptr_vld", 8'h1, {7'h0, pointer_valid_o});
		m.start;
		m.xfer(8'hdf, ack);
		chk("rd", 8'h1, {7'h0, read_o});
		m.stop;
	endtask
	task t_calls;
		logic [7:0] a [5] = '{8'he0, 8'he1, 8'hd4, 8'hd5, 8'h22};
		for (int i = 0; i < 5; i++)
			frame(a[i], i < 4);
	endtask
	task t_prog;
		@(posedge clk_i);
		sub_call_address_i <= 8'h30;
		sub_call_wr_i <= 3'h2;
		sub_call_en_i <= 3'h2;
		sub_call_en_wr_i <= 1'b1;
		group_call_address_i <= 8'ha0;
		group_call_en_i <= 1'b1;
		group_call_wr_i <= 1'b1;
		@(posedge clk_i);
		{sub_call_wr_i, sub_call_en_wr_i, group_call_wr_i} <= '0;
		@(posedge clk_i);
		chk("grp_wr", 8'ha0, group_call_address_o);
		chk("sub_b_wr", 8'h30, sub_call_address_b_o);
		chk("sub_en_wr", 8'h2, {5'h0, sub_call_en_o});
		frame(8'h30, 1'b1);
		frame(8'hd4, 1'b0);
		frame(8'ha0, 1'b1);
		frame(8'he0, 1'b0);
	endtask
	task t_reset_call;
		@(posedge clk_i);
		addr_pad_two_i <= 3'h0;
		addr_pad_one_i <= 3'h0;
		repeat (20) @(posedge clk_i);
		chk("own", 8'h6f, {1'b0, own_address_o});
		m.start;
		m.xfer(8'h00, ack);
		m.xfer(8'h06, ack);
		m.stop;
		repeat (20) @(posedge clk_i);
		chk("grp", 8'he0, group_call_address_o);
		chk("sub_en", 8'h1, {5'h0, sub_call_en_o});
		chk("sub_b", 8'hd4, sub_call_address_b_o);
		chk("own", 8'h01, {1'b0, own_address_o});
		frame(8'h02, 1'b1);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		t_defaults;
		t_own;
		t_calls;
		t_prog;
		t_reset_call;
		end_sim;
	end
endmodule // i2c_target_address_match_tb_top

/* pad_level_decode.v */
/*
 Combines three quinary pad levels into the 7-bit target address.
 Assumes level codes 0..4 from the pad sense comparators.
*/
`timescale 1ns/100ps
`include "addr_match_map.vh"

module pad_level_decode (
	// Pad levels
	input wire [2:0] addr_pad_zero_i,
	input wire [2:0] addr_pad_one_i,
	input wire [2:0] addr_pad_two_i,
	// Result
	output wire [6:0] address_o,
	output wire valid_o
);
	wire [6:0] two_term;
	wire [6:0] one_term;
	assign two_term = `PAD_TWO_WEIGHT * {4'h0, addr_pad_two_i};
	assign one_term = `PAD_ONE_WEIGHT * {4'h0, addr_pad_one_i};
	assign address_o = two_term + one_term + {4'h0, addr_pad_zero_i} + `ADDR_OFFSET;
	// Codes above tied high are not legal levels
	assign valid_o = (addr_pad_zero_i <= `LEVEL_TIED_HIGH) && (addr_pad_one_i <= `LEVEL_TIED_HIGH) &&
		(addr_pad_two_i <= `LEVEL_TIED_HIGH);
endmodule // pad_level_decode
